// ==== rtl/tmr8_unit.sv ====
`timescale 1ns/1ns
module tmr8_unit (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [2:0] clock_source_select,
    input wire logic [7:0] prescale_taps,
    input wire logic ext_clock_pin,
    input wire logic [1:0] waveform_mode_select,
    input wire logic [1:0] compare_output_action,
    input wire logic counter_wr,
    input wire logic [7:0] counter_wdata,
    input wire logic compare_wr,
    input wire logic [7:0] compare_wdata,
    input wire logic force_compare_strobe,
    input wire logic compare_flag_w1c,
    input wire logic overflow_flag_w1c,
    input wire logic compare_irq_enable,
    input wire logic overflow_irq_enable,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic port_out_value,
    input wire logic output_pin_direction,
    output logic [7:0] counter_value,
    output logic [7:0] compare_value,
    output logic compare_match_flag,
    output logic overflow_flag,
    output logic compare_irq,
    output logic overflow_irq,
    output logic waveform_output_state,
    output logic pin_out,
    output logic pin_oe_n,
    output logic top_flag,
    output logic bottom_flag
);
    tmr8_tick_if tick_bus ();
    assign tick_bus.clock_source_select = clock_source_select;
    assign tick_bus.prescale_taps = prescale_taps;
    assign tick_bus.ext_pin = ext_clock_pin;

    tmr8_tick_sel u_tick (
        .clock(clock),
        .nrst(nrst),
        .tick(tick_bus.selector)
    );

    logic [7:0] cnt_q, cnt_d;
    logic [7:0] ocr_q, ocr_d;
    logic [7:0] obuf_q, obuf_d;
    logic down_q, down_d;
    logic block_q, block_d;
    logic ocf_q, tov_q, wave_q, wave_d;
    logic cirq_q, oirq_q, pin_q, oe_n_q, top_q, bot_q;

    wire tick = tick_bus.timer_tick;
    wire tmr8_pkg::tmr8_mode_type mode = tmr8_pkg::tmr8_mode_type'(waveform_mode_select);
    wire tmr8_pkg::tmr8_action_type act = tmr8_pkg::tmr8_action_type'(compare_output_action);
    wire is_pwm = mode == tmr8_pkg::tmr8_pc_pwm || mode == tmr8_pkg::tmr8_fast_pwm;

    // comparator and extremes
    wire cmp_eq = cnt_q == ocr_q;
    wire at_max = cnt_q == tmr8_pkg::tmr8_max;
    wire at_bottom = cnt_q == tmr8_pkg::tmr8_bottom;
    wire at_top = (mode == tmr8_pkg::tmr8_ctc) ? cmp_eq : at_max;
    // a counter write blanks matches until the next tick has passed
    wire match_ok = cmp_eq & ~block_q & ~counter_wr;

    // counting step per mode
    logic [7:0] step_val;
    logic step_down;
    always_comb begin
        step_val = cnt_q + 8'h01;
        step_down = down_q;
        unique case (mode)
            tmr8_pkg::tmr8_normal: step_val = cnt_q + 8'h01;
            tmr8_pkg::tmr8_ctc: step_val = cmp_eq ? tmr8_pkg::tmr8_bottom : cnt_q + 8'h01;
            tmr8_pkg::tmr8_fast_pwm: step_val = at_max ? tmr8_pkg::tmr8_bottom : cnt_q + 8'h01;
            tmr8_pkg::tmr8_pc_pwm: begin
                if (at_max) begin
                    step_down = 1'b1;
                end else if (at_bottom) begin
                    step_down = 1'b0;
                end
                step_val = step_down ? cnt_q - 8'h01 : cnt_q + 8'h01;
            end
        endcase
    end

    // overflow point per mode
    wire ovf_evt = tick & ((mode == tmr8_pkg::tmr8_pc_pwm) ? at_bottom && down_q : at_max);

    // active-register update: direct when unbuffered, at MAX in both PWM modes when buffered
    wire load_pt = (mode == tmr8_pkg::tmr8_pc_pwm) ? at_max : at_max;
    wire buf_load = is_pwm & tick & load_pt;

    // waveform action on a match, or on a forced match in the non-PWM modes only
    logic match_hit, pwm_bottom_hit;
    always_comb begin
        match_hit = tick & match_ok;
        pwm_bottom_hit = tick & (mode == tmr8_pkg::tmr8_fast_pwm) & at_max;
    end

    wire force_hit = force_compare_strobe & ~is_pwm;
    wire act_hit = match_hit | force_hit;

    always_comb begin
        wave_d = wave_q;
        if (is_pwm) begin
            if (act == tmr8_pkg::tmr8_act_toggle && mode == tmr8_pkg::tmr8_fast_pwm) begin
                if (match_hit) begin
                    wave_d = ~wave_q;
                end
            end else if (act[1]) begin
                // act[0] selects inverting polarity
                if (mode == tmr8_pkg::tmr8_fast_pwm) begin
                    if (match_hit) begin
                        wave_d = act[0];
                    end else if (pwm_bottom_hit) begin
                        wave_d = ~act[0];
                    end
                end else if (match_hit) begin
                    wave_d = down_q ? ~act[0] : act[0];
                end
            end
        end else if (act_hit) begin
            // action field read live, no buffering
            unique case (act)
                tmr8_pkg::tmr8_act_none: wave_d = wave_q;
                tmr8_pkg::tmr8_act_toggle: wave_d = ~wave_q;
                tmr8_pkg::tmr8_act_clear: wave_d = 1'b0;
                tmr8_pkg::tmr8_act_set: wave_d = 1'b1;
            endcase
        end
    end

    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        if (counter_wr) begin
            cnt_d = counter_wdata;
        end else if (tick) begin
            cnt_d = step_val;
            down_d = (mode == tmr8_pkg::tmr8_pc_pwm) ? step_down : 1'b0;
        end
        if (mode != tmr8_pkg::tmr8_pc_pwm) begin
            down_d = 1'b0;
        end
    end

    always_comb begin
        ocr_d = ocr_q;
        obuf_d = obuf_q;
        if (compare_wr && is_pwm) begin
            obuf_d = compare_wdata;
        end
        if (compare_wr && !is_pwm) begin
            ocr_d = compare_wdata;
            obuf_d = compare_wdata;
        end else if (buf_load) begin
            ocr_d = obuf_q;
        end
    end

    // block spans from a write until the following tick is consumed
    always_comb begin
        block_d = block_q;
        if (counter_wr) begin
            block_d = 1'b1;
        end else if (tick) begin
            block_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_q <= tmr8_pkg::tmr8_cnt_rst;
            ocr_q <= tmr8_pkg::tmr8_cmp_rst;
            obuf_q <= tmr8_pkg::tmr8_cmp_rst;
            down_q <= 1'b0;
            block_q <= 1'b0;
            wave_q <= tmr8_pkg::tmr8_wave_rst;
        end else begin
            cnt_q <= cnt_d;
            ocr_q <= ocr_d;
            obuf_q <= obuf_d;
            down_q <= down_d;
            block_q <= block_d;
            wave_q <= wave_d;
        end
    end

    // flag set wins over a clear in the same cycle
    // the match seen in this cycle is flagged at the closing edge of its tick
    wire ocf_set = tick & match_ok;
    wire ocf_clr = compare_flag_w1c | compare_irq_ack;
    wire tov_clr = overflow_flag_w1c | overflow_irq_ack;
    wire ocf_d_v = ocf_set | (ocf_q & ~ocf_clr);
    wire tov_d_v = ovf_evt | (tov_q & ~tov_clr);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ocf_q <= 1'b0;
            tov_q <= 1'b0;
        end else begin
            ocf_q <= ocf_set | (ocf_q & ~ocf_clr);
            tov_q <= ovf_evt | (tov_q & ~tov_clr);
        end
    end

    wire pin_sel = |compare_output_action;
    wire pin_val = pin_sel ? wave_d : port_out_value;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cirq_q <= 1'b0;
            oirq_q <= 1'b0;
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
            top_q <= 1'b0;
            bot_q <= 1'b1;
        end else begin
            cirq_q <= ocf_d_v & compare_irq_enable & global_irq_enable;
            oirq_q <= tov_d_v & overflow_irq_enable & global_irq_enable;
            pin_q <= pin_val;
            oe_n_q <= ~output_pin_direction;
            top_q <= cnt_d == tmr8_pkg::tmr8_max;
            bot_q <= cnt_d == tmr8_pkg::tmr8_bottom;
        end
    end

    assign counter_value = cnt_q;
    assign compare_value = is_pwm ? obuf_q : ocr_q;
    assign compare_match_flag = ocf_q;
    assign overflow_flag = tov_q;
    assign compare_irq = cirq_q;
    assign overflow_irq = oirq_q;
    assign waveform_output_state = wave_q;
    assign pin_out = pin_q;
    assign pin_oe_n = oe_n_q;
    assign top_flag = top_q;
    assign bottom_flag = bot_q;

    cnt_write_a: assert property (@(posedge clock) disable iff (!nrst)
        counter_wr |=> cnt_q == $past(counter_wdata))
        else $error("counter write lost");
    cnt_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !tick && !counter_wr |=> $stable(cnt_q))
        else $error("counter moved without tick");
    flag_late_a: assert property (@(posedge clock) disable iff (!nrst)
        tick && match_ok ##1 (!tick && !counter_wr) [*2] |-> !ocf_set)
        else $error("match flag set without tick");
    flag_set_a: assert property (@(posedge clock) disable iff (!nrst)
        ocf_set |=> ocf_q)
        else $error("set lost against clear");
    flag_w1c_a: assert property (@(posedge clock) disable iff (!nrst)
        compare_flag_w1c && !ocf_set |=> !ocf_q)
        else $error("flag not cleared");
    irq_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        compare_irq |-> $past(compare_irq_enable) && $past(global_irq_enable))
        else $error("irq without enables");
    block_a: assert property (@(posedge clock) disable iff (!nrst)
        counter_wr ##1 tick |=> !ocf_q || $past(ocf_q))
        else $error("blocked match flagged");
    no_act_a: assert property (@(posedge clock) disable iff (!nrst)
        act == tmr8_pkg::tmr8_act_none && !is_pwm |=> $stable(wave_q))
        else $error("wave changed with no action");
    direct_cmp_a: assert property (@(posedge clock) disable iff (!nrst)
        compare_wr && !is_pwm |=> ocr_q == $past(compare_wdata))
        else $error("direct compare write lost");
endmodule

// ==== rtl/tmr8_pkg.sv ====
package tmr8_pkg;
    localparam logic [7:0] tmr8_bottom = 8'h00;
    localparam logic [7:0] tmr8_max = 8'hFF;
    localparam logic [7:0] tmr8_cnt_rst = 8'h00;
    localparam logic [7:0] tmr8_cmp_rst = 8'h00;
    localparam logic [2:0] tmr8_cs_off = 3'h0;
    localparam logic [2:0] tmr8_cs_ext_fall = 3'h6;
    localparam logic [2:0] tmr8_cs_ext_rise = 3'h7;
    localparam logic tmr8_wave_rst = 1'b0;

    typedef enum logic [1:0] {
        tmr8_normal = 2'b00,
        tmr8_pc_pwm = 2'b01,
        tmr8_ctc = 2'b10,
        tmr8_fast_pwm = 2'b11
    } tmr8_mode_type;

    typedef enum logic [1:0] {
        tmr8_act_none = 2'b00,
        tmr8_act_toggle = 2'b01,
        tmr8_act_clear = 2'b10,
        tmr8_act_set = 2'b11
    } tmr8_action_type;
endpackage

// ==== rtl/tmr8_tick_if.sv ====
`timescale 1ns/1ns
interface tmr8_tick_if;
    logic [2:0] clock_source_select;
    logic [7:0] prescale_taps;
    logic ext_pin;
    logic timer_tick;
    modport selector (input clock_source_select, input prescale_taps, input ext_pin,
                      output timer_tick);
    modport counter (output clock_source_select, output prescale_taps, output ext_pin,
                     input timer_tick);
endinterface

// ==== rtl/tmr8_tick_sel.sv ====
`timescale 1ns/1ns
module tmr8_tick_sel (
    input wire logic clock,
    input wire logic nrst,
    tmr8_tick_if.selector tick
);
    logic [2:0] ext_sync_q;
    logic tick_q;
    wire ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
    wire ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
    logic sel_tick;

    // zero selects nothing: no ticks at all
    always_comb begin
        unique case (tick.clock_source_select)
            tmr8_pkg::tmr8_cs_off: sel_tick = 1'b0;
            tmr8_pkg::tmr8_cs_ext_fall: sel_tick = ext_fall;
            tmr8_pkg::tmr8_cs_ext_rise: sel_tick = ext_rise;
            default: sel_tick = tick.prescale_taps[tick.clock_source_select];
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ext_sync_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], tick.ext_pin};
            tick_q <= sel_tick;
        end
    end

    assign tick.timer_tick = tick_q;

    no_tick_off_a: assert property (@(posedge clock) disable iff (!nrst)
        $past(tick.clock_source_select) == tmr8_pkg::tmr8_cs_off |-> !tick_q)
        else $error("tick while clock source off");
endmodule

// ==== bench/tmr8_unit_tb.sv ====
`timescale 1ns/1ns
`define CHK(g, e) check_val(8'(g), 8'(e))
module tmr8_unit_tb;
    logic clock = 1'h0;
    logic nrst = 1'h0;
    logic [2:0] clock_source_select = 3'h0;
    logic [7:0] prescale_taps = 8'hFF;
    logic ext_clock_pin = 1'h0;
    logic [1:0] waveform_mode_select = 2'h0;
    logic [1:0] compare_output_action = 2'h0;
    logic counter_wr = 1'h0, compare_wr = 1'h0, force_compare_strobe = 1'h0;
    logic [7:0] counter_wdata = 8'h00, compare_wdata = 8'h00;
    logic compare_flag_w1c = 1'h0, overflow_flag_w1c = 1'h0, compare_irq_enable = 1'h0;
    logic overflow_irq_enable = 1'h0, global_irq_enable = 1'h0, compare_irq_ack = 1'h0;
    logic overflow_irq_ack = 1'h0, port_out_value = 1'h0, output_pin_direction = 1'h0;
    logic [7:0] counter_value, compare_value;
    logic compare_match_flag, overflow_flag, compare_irq, overflow_irq;
    logic waveform_output_state, pin_out, pin_oe_n, top_flag, bottom_flag;
    int errors = 0;
    int tests_run = 0;

    tmr8_unit i_tmr8_unit (.clock, .nrst, .clock_source_select, .prescale_taps,
        .ext_clock_pin, .waveform_mode_select, .compare_output_action, .counter_wr,
        .counter_wdata, .compare_wr, .compare_wdata, .force_compare_strobe,
        .compare_flag_w1c, .overflow_flag_w1c, .compare_irq_enable, .overflow_irq_enable,
        .global_irq_enable, .compare_irq_ack, .overflow_irq_ack, .port_out_value,
        .output_pin_direction, .counter_value, .compare_value, .compare_match_flag,
        .overflow_flag, .compare_irq, .overflow_irq, .waveform_output_state, .pin_out,
        .pin_oe_n, .top_flag, .bottom_flag);

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic check_val(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // sample one time unit after the edge so registered outputs have settled
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr_cnt(logic [7:0] v);
        @(posedge clock);
        counter_wr <= 1'h1;
        counter_wdata <= v;
        @(posedge clock);
        counter_wr <= 1'h0;
        #1;
    endtask

    task automatic wr_cmp(logic [7:0] v);
        @(posedge clock);
        compare_wr <= 1'h1;
        compare_wdata <= v;
        @(posedge clock);
        compare_wr <= 1'h0;
        #1;
    endtask

    // 0 force, 1 compare service, 2 compare flag clear, 3 overflow flag clear
    task automatic pulse(int k);
        @(posedge clock);
        case (k)
            0: force_compare_strobe <= 1'h1;
            1: compare_irq_ack <= 1'h1;
            2: compare_flag_w1c <= 1'h1;
            default: overflow_flag_w1c <= 1'h1;
        endcase
        @(posedge clock);
        {force_compare_strobe, compare_irq_ack, compare_flag_w1c, overflow_flag_w1c} <= 4'h0;
        #1;
    endtask

    task automatic t_reset();
        `CHK(counter_value, 8'h00);
        `CHK(compare_value, 8'h00);
        `CHK(waveform_output_state, 1'h0);
        `CHK(bottom_flag, 1'h1);
        `CHK(top_flag, 1'h0);
        `CHK(pin_oe_n, 1'h1);
    endtask

    task automatic t_stop_and_count();
        logic [7:0] a;
        cyc(10);
        `CHK(counter_value, 8'h00);
        wr_cnt(8'h5A);
        `CHK(counter_value, 8'h5A);
        cyc(5);
        `CHK(counter_value, 8'h5A);
        @(posedge clock) clock_source_select <= 3'h1;
        cyc(3);
        a = counter_value;
        cyc(1);
        `CHK(counter_value, a + 8'h01);
        wr_cnt(8'h40);
        `CHK(counter_value, 8'h40);
        cyc(1);
        `CHK(counter_value, 8'h41);
        for (int i = 0; i < 300; i++) begin
            cyc(1);
            `CHK(top_flag, counter_value == 8'hFF);
            `CHK(bottom_flag, counter_value == 8'h00);
        end
        `CHK(overflow_flag, 1'h1);
        @(posedge clock) begin
            overflow_irq_enable <= 1'h1;
            global_irq_enable <= 1'h1;
        end
        cyc(2);
        `CHK(overflow_irq, 1'h1);
        pulse(3);
        cyc(1);
        `CHK(overflow_flag, 1'h0);
        @(posedge clock) global_irq_enable <= 1'h0;
    endtask

    task automatic t_match();
        @(posedge clock) clock_source_select <= 3'h0;
        pulse(2);
        wr_cmp(8'h20);
        `CHK(compare_value, 8'h20);
        wr_cnt(8'h10);
        @(posedge clock) begin
            compare_irq_enable <= 1'h1;
            clock_source_select <= 3'h1;
        end
        for (int i = 0; i < 40 && compare_match_flag !== 1'h1; i++) cyc(1);
        // the match at 0x20 lands together with the step to 0x21
        `CHK(counter_value, 8'h21);
        cyc(2);
        `CHK(compare_irq, 1'h0);
        @(posedge clock) global_irq_enable <= 1'h1;
        cyc(2);
        `CHK(compare_irq, 1'h1);
        pulse(1);
        cyc(1);
        `CHK(compare_match_flag, 1'h0);
        for (int i = 0; i < 300 && compare_match_flag !== 1'h1; i++) cyc(1);
        pulse(2);
        cyc(1);
        `CHK(compare_match_flag, 1'h0);
        // a stopped counter written to the compare value must not match on restart
        @(posedge clock) clock_source_select <= 3'h0;
        wr_cnt(8'h20);
        pulse(2);
        @(posedge clock) clock_source_select <= 3'h1;
        cyc(6);
        `CHK(compare_match_flag, 1'h0);
    endtask

    task automatic t_ctc();
        logic [7:0] top_seen;
        top_seen = 8'h00;
        @(posedge clock) begin
            clock_source_select <= 3'h0;
            waveform_mode_select <= 2'h2;
        end
        wr_cmp(8'h05);
        wr_cnt(8'h00); // bottom written while the counter is stopped
        @(posedge clock) clock_source_select <= 3'h1;
        for (int i = 0; i < 20; i++) begin
            cyc(1);
            if (counter_value > top_seen) top_seen = counter_value;
        end
        `CHK(top_seen, 8'h05);
        `CHK(waveform_output_state, 1'h0);
    endtask

    task automatic t_force();
        logic [1:0] acts[5] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h0};
        logic outs[5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
        logic [7:0] held;
        @(posedge clock) begin
            clock_source_select <= 3'h0;
            waveform_mode_select <= 2'h0;
        end
        pulse(2);
        held = counter_value;
        for (int k = 0; k < 5; k++) begin
            @(posedge clock) compare_output_action <= acts[k];
            pulse(0);
            cyc(1);
            `CHK(waveform_output_state, outs[k]);
            `CHK(compare_match_flag, 1'h0);
            `CHK(counter_value, held);
        end
        @(posedge clock) begin
            waveform_mode_select <= 2'h3;
            compare_output_action <= 2'h1;
        end
        pulse(0);
        cyc(1);
        `CHK(waveform_output_state, 1'h0);
        wr_cmp(8'h77);
        `CHK(compare_value, 8'h77);
        @(posedge clock) begin
            waveform_mode_select <= 2'h0;
            compare_output_action <= 2'h3;
        end
        pulse(0);
        @(posedge clock) waveform_mode_select <= 2'h3;
        cyc(2);
        `CHK(waveform_output_state, 1'h1);
    endtask

    task automatic t_pin();
        @(posedge clock) output_pin_direction <= 1'h1;
        cyc(2);
        `CHK(pin_out, 1'h1);
        `CHK(pin_oe_n, 1'h0);
        @(posedge clock) compare_output_action <= 2'h0;
        cyc(2);
        `CHK(pin_out, 1'h0);
        @(posedge clock) output_pin_direction <= 1'h0;
        cyc(2);
        `CHK(pin_oe_n, 1'h1);
        @(posedge clock) nrst <= 1'h0;
        cyc(2);
        `CHK(waveform_output_state, 1'h0);
        @(posedge clock) nrst <= 1'h1;
        cyc(1);
    endtask

    initial begin
        #100000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        cyc(1);
        t_reset();
        t_stop_and_count();
        t_match();
        t_ctc();
        t_force();
        t_pin();
        report_and_stop();
    end
endmodule
